// ==== core/fedc_slice.sv ====
// flow-through edc slice: system and memory data paths with diagnostics
`timescale 1ns/1ps
`default_nettype none
module fedc_slice (
  // clock and reset
  input  wire logic                         sys_clk_i,
  input  wire logic                         resetn_i,
  // static configuration
  input  wire logic [2:0]                   mode_select_i,
  input  wire logic [1:0]                   slice_config_i,
  input  wire logic                         parity_odd_i,
  // system bus
  input  wire logic [fedc_pkg::DATA_W-1:0]  system_bus_i,
  output var  logic [fedc_pkg::DATA_W-1:0]  system_bus_o,
  output var  logic [fedc_pkg::BYTES-1:0]   system_bus_oe_o,
  input  wire logic [fedc_pkg::BYTES-1:0]   parity_i,
  output var  logic [fedc_pkg::BYTES-1:0]   parity_o,
  output var  logic [fedc_pkg::BYTES-1:0]   parity_oe_o,
  input  wire logic [fedc_pkg::BYTES-1:0]   byte_enable_n_i,
  input  wire logic                         system_output_enable_n_i,
  output var  logic                         parity_fail_n_o,
  // latch loads
  input  wire logic                         sys_latch_en_i,
  input  wire logic                         mem_latch_en_i,
  input  wire logic                         pipe_latch_en_i,
  // memory bus
  input  wire logic [fedc_pkg::DATA_W-1:0]  memory_bus_i,
  output var  logic [fedc_pkg::DATA_W-1:0]  memory_bus_o,
  output var  logic                         memory_bus_oe_o,
  input  wire logic                         mem_write_i,
  output var  logic                         mem_write_ready_o,
  input  wire logic                         mem_accept_i,
  // check bits and syndrome
  input  wire logic [fedc_pkg::CB_W-1:0]    checkbit_in_i,
  input  wire logic [fedc_pkg::CB_W-1:0]    partial_checkbit_in_i,
  output var  logic [fedc_pkg::CB_W-1:0]    checkbit_out_o,
  output var  logic [fedc_pkg::CB_W-1:0]    syndrome_out_o,
  output var  logic                         error_n_o,
  // diagnostics
  input  wire logic                         diag_clock_i,
  input  wire logic                         diag_clock_enable_n_i,
  input  wire logic                         diag_clear_i
);
  import fedc_pkg::*;

  // data latches
  logic [DATA_W-1:0]  sys_latch;
  logic [DATA_W-1:0]  mem_latch;
  logic [DATA_W-1:0]  pipe_latch;
  // diagnostic registers
  logic [DATA_W-1:0]  first_error_data;
  logic [CB_W-1:0]    first_error_syndrome;
  logic [TALLY_W-1:0] error_tally;
  logic [TYPE_W-1:0]  error_type_flags;
  logic               diag_prev;

  // configuration decode
  wire gen64    = slice_config_i == CFG_GEN64;
  wire is_lower = slice_config_i == CFG_LOWER;
  wire is_upper = slice_config_i == CFG_UPPER;
  wire cascaded = is_lower | is_upper;
  wire [7:0] cb_used = cascaded ? CB_USED_64 : CB_USED_32;

  // mode decode, static pins set from outside
  wire m_err    = mode_select_i == MODE_ERRDATA;
  wire m_inject = mode_select_i == MODE_INJECT;
  wire m_diag   = mode_select_i[1:0] == MODE_DIAG;
  wire m_gendet = mode_select_i[1:0] == MODE_GENDET;
  wire m_norm   = mode_select_i[1:0] == MODE_NORMAL;
  wire correct_en = m_norm | m_inject;

  // check-bit mux and detect path
  wire [CB_W-1:0] cb_mux = m_inject ? sys_latch[7:0] : checkbit_in_i;
  wire [CB_W-1:0] gen_mem_lo = fedc_gen(mem_latch, COL_W_LO);
  wire [CB_W-1:0] gen_mem_hi = fedc_gen(mem_latch, COL_W_HI);
  wire [CB_W-1:0] gen_mem = (is_upper ? gen_mem_hi : gen_mem_lo) & cb_used;
  wire [CB_W-1:0] part_syn = (gen_mem ^ cb_mux) & cb_used;
  wire [CB_W-1:0] lower_syn = part_syn ^ partial_checkbit_in_i;
  wire [CB_W-1:0] upper_syn = (cb_mux ^ gen_mem) & cb_used;
  wire [CB_W-1:0] final_syn = is_upper ? upper_syn : (is_lower ? lower_syn : part_syn);
  wire [CB_W-1:0] next_syn_out = is_upper ? gen_mem : part_syn;

  // error classification
  wire [DATA_W-1:0] flip_lo = fedc_flip(final_syn, COL_W_LO);
  wire [DATA_W-1:0] flip_hi = fedc_flip(final_syn, COL_W_HI);
  wire [DATA_W-1:0] flip = is_upper ? flip_hi : flip_lo;
  wire syn_nz  = (final_syn != 8'h00) & ~gen64;
  wire cb_hit  = $countones(final_syn) == 1;
  wire single  = syn_nz & ((flip != 32'h0000_0000) | cb_hit);
  wire multi   = syn_nz & ~single;
  wire [TYPE_W-1:0] err_type = multi ? TYPE_MULTI : TYPE_SINGLE;

  // correction
  wire [DATA_W-1:0] corrected = correct_en ? (mem_latch ^ flip) : mem_latch;

  // byte merge for writes
  logic [DATA_W-1:0] merged;
  for (genvar b = 0; b < BYTES; b++) begin : g_merge
    assign merged[8*b +: 8] = byte_enable_n_i[b] ? pipe_latch[8*b +: 8] : sys_latch[8*b +: 8];
  end

  // write check bits
  wire [CB_W-1:0] gen_wr_lo = fedc_gen(merged, COL_W_LO);
  wire [CB_W-1:0] gen_wr_hi = fedc_gen(merged, COL_W_HI);
  wire [CB_W-1:0] gen_wr = (is_upper ? gen_wr_hi : gen_wr_lo) & cb_used;
  wire [CB_W-1:0] cb_write = is_upper ? (gen_wr ^ partial_checkbit_in_i) : gen_wr;
  wire [CB_W-1:0] cb_gen64 = fedc_gen(mem_latch, COL_W_LO) ^ fedc_gen(sys_latch, COL_W_HI);
  wire [CB_W+DATA_W-1:0] wr_word = gen64 ? {cb_gen64, mem_latch} : {cb_write, merged};

  // diagnostic word
  wire [DATA_W-1:0] diag_word = {error_type_flags, DIAG_RSVD, error_tally,
                                 first_error_syndrome, partial_checkbit_in_i, cb_mux};

  // system bus data by mode
  wire [DATA_W-1:0] next_sys_out = m_err ? first_error_data :
                                   m_diag ? diag_word :
                                   m_gendet ? mem_latch :
                                   corrected;

  // per-byte drivers, parity generate and check
  logic [BYTES-1:0] next_oe;
  logic [BYTES-1:0] next_par;
  logic [BYTES-1:0] par_bad;
  for (genvar b = 0; b < BYTES; b++) begin : g_byte
    assign next_oe[b]  = ~system_output_enable_n_i & ~byte_enable_n_i[b] & ~gen64;
    assign next_par[b] = ^next_sys_out[8*b +: 8] ^ parity_odd_i;
    assign par_bad[b]  = ~system_bus_oe_o[b] & ((^{system_bus_i[8*b +: 8], parity_i[b]}) != parity_odd_i);
  end
  wire next_par_fail_n = ~((|par_bad) & ~gen64);

  // diagnostic capture and counting
  wire diag_edge = diag_clock_i & ~diag_prev;
  wire err_evt   = diag_edge & syn_nz & ~diag_clock_enable_n_i;
  wire [TALLY_W-1:0] base_tally = diag_clear_i ? TALLY_RST : error_tally;
  wire capture   = err_evt & (base_tally == TALLY_RST);
  wire count_up  = err_evt & (base_tally != TALLY_MAX);
  wire [TALLY_W-1:0] next_tally = count_up ? base_tally + 4'h1 : base_tally;

  // buffered write path to memory
  logic wr_ready;
  logic [CB_W+DATA_W-1:0] buf_out;
  fedc_pair_buf #(.W(CB_W + DATA_W)) u_wbuf (
    .sys_clk_i  (sys_clk_i),
    .resetn_i   (resetn_i),
    .in_valid_i (mem_write_i),
    .in_data_i  (wr_word),
    .in_ready_o (wr_ready),
    .out_valid_o(memory_bus_oe_o),
    .out_data_o (buf_out),
    .out_ready_i(mem_accept_i)
  );
  assign mem_write_ready_o = wr_ready;
  assign memory_bus_o      = buf_out[DATA_W-1:0];
  assign checkbit_out_o    = buf_out[CB_W+DATA_W-1:DATA_W];

  // latches
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sys_latch  <= 32'h0000_0000;
      mem_latch  <= 32'h0000_0000;
      pipe_latch <= 32'h0000_0000;
    end else begin
      if (sys_latch_en_i) sys_latch <= system_bus_i;
      if (mem_latch_en_i) mem_latch <= memory_bus_i;
      if (pipe_latch_en_i) pipe_latch <= corrected;
    end
  end

  // diagnostic registers, capture wins over clear
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      diag_prev            <= 1'b0;
      first_error_data     <= ERRDATA_RST;
      first_error_syndrome <= SYN_RST;
      error_type_flags     <= TYPE_RST;
      error_tally          <= TALLY_RST;
    end else begin
      diag_prev   <= diag_clock_i;
      error_tally <= next_tally;
      if (capture) begin
        first_error_data     <= mem_latch;
        first_error_syndrome <= final_syn;
        error_type_flags     <= err_type;
      end else if (diag_clear_i) begin
        first_error_data     <= ERRDATA_RST;
        first_error_syndrome <= SYN_RST;
        error_type_flags     <= TYPE_RST;
      end
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      system_bus_o    <= 32'h0000_0000;
      system_bus_oe_o <= 4'h0;
      parity_o        <= 4'h0;
      parity_oe_o     <= 4'h0;
      parity_fail_n_o <= 1'b1;
      syndrome_out_o  <= 8'h00;
      error_n_o       <= 1'b1;
    end else begin
      system_bus_o    <= next_sys_out;
      system_bus_oe_o <= next_oe;
      parity_o        <= next_par;
      parity_oe_o     <= next_oe;
      parity_fail_n_o <= next_par_fail_n;
      syndrome_out_o  <= next_syn_out;
      error_n_o       <= ~syn_nz;
    end
  end

  // checks
  a_errdata_drive: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    m_err |=> system_bus_o == $past(first_error_data))
    else $error("error data mode output mismatch");

  a_first_capture: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    capture |=> first_error_data == $past(mem_latch) && error_tally == 4'h1)
    else $error("first error not captured");

  a_no_recapture: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    error_tally != 4'h0 && !diag_clear_i |=> $stable(first_error_data))
    else $error("error data changed after first error");

  a_clear_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    diag_clear_i && !err_evt |=> first_error_data == 32'h0 && error_tally == 4'h0
      && first_error_syndrome == 8'h00 && error_type_flags == 2'h0)
    else $error("clear did not zero diagnostics");

  a_diag_low: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    m_diag |=> system_bus_o[7:0] == $past(cb_mux))
    else $error("diagnostic check-bit field wrong");

  a_diag_pins: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    m_diag |=> system_bus_o[15:8] == $past(partial_checkbit_in_i))
    else $error("diagnostic partial check-bit field wrong");

  a_syn_capture: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    capture ##1 m_diag |=> system_bus_o[23:16] == $past(final_syn, 2))
    else $error("syndrome register not shown");

  a_tally_sat: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    error_tally == 4'hf && !diag_clear_i |=> error_tally == 4'hf)
    else $error("tally left saturation");

  a_tally_step: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    err_evt && !diag_clear_i && error_tally != 4'hf |=> error_tally == $past(error_tally) + 4'h1)
    else $error("tally did not count");

  a_type_multi: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    capture && multi |=> error_type_flags == 2'h3)
    else $error("multiple error type wrong");

  a_gendet_pass: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    m_gendet |=> system_bus_o == $past(mem_latch))
    else $error("generate-detect altered data");

  a_parity_gen: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    1'b1 |=> (^system_bus_o[7:0] ^ parity_o[0]) == $past(parity_odd_i))
    else $error("byte parity wrong");

  a_byte_drive: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    system_output_enable_n_i |=> system_bus_oe_o == 4'h0)
    else $error("drivers on while disabled");

  a_gen64_quiet: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    gen64 |=> error_n_o && system_bus_oe_o == 4'h0)
    else $error("64-bit generate not isolated");

  a_flag_follows: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    syn_nz |=> !error_n_o)
    else $error("error flag missed");
endmodule // fedc_slice
`default_nettype wire

// ==== core/fedc_pkg.sv ====
// constants and check-bit code helpers for the flow-through edc slice
// How it works
// - mode 000 drives captured error data uncorrected
// - error data loads on first enabled error
// - cleared error data reads as zero word
// - diagnostic word bits 0:7 hold check-bit mux
// - diagnostic bits 8:15 mirror partial check-bit pins
// - syndrome register captures with error data, bits 16:23
// - error tally counts enabled errors, saturates at 1111
// - error type loads with syndrome; multiple both, single bit1
// - generate-detect passes memory data uncorrected
// - normal mode generates, detects, corrects; standalone or cascaded
// - injection mode feeds system latch bits 0:7 as check bits
// - byte parity per system byte, even or odd
// - parity fail output low on bad incoming parity
// - each byte enable with output enable gates drivers
// - byte merge picks system latch when enable low
// - partial write merges corrected pipeline word and new byte
// - config 01 generates 64-bit check bits only
// - seven check bits standalone, eight when cascaded
`default_nettype none
package fedc_pkg;
  localparam int DATA_W  = 32;
  localparam int CB_W    = 8;
  localparam int TALLY_W = 4;
  localparam int TYPE_W  = 2;
  localparam int BYTES   = 4;
  // mode select codes
  localparam logic [2:0] MODE_ERRDATA = 3'h0;
  localparam logic [2:0] MODE_INJECT  = 3'h4;
  localparam logic [1:0] MODE_DIAG    = 2'h1;
  localparam logic [1:0] MODE_GENDET  = 2'h2;
  localparam logic [1:0] MODE_NORMAL  = 2'h3;
  // slice configuration codes
  localparam logic [1:0] CFG_STANDALONE = 2'h0;
  localparam logic [1:0] CFG_GEN64      = 2'h1;
  localparam logic [1:0] CFG_LOWER      = 2'h2;
  localparam logic [1:0] CFG_UPPER      = 2'h3;
  // diagnostic word fields
  localparam int DIAG_CB_LSB    = 0;
  localparam int DIAG_PCB_LSB   = 8;
  localparam int DIAG_SYN_LSB   = 16;
  localparam int DIAG_TALLY_LSB = 24;
  localparam int DIAG_RSVD_LSB  = 28;
  localparam int DIAG_TYPE_LSB  = 30;
  // reset and fixed values
  localparam logic [31:0] ERRDATA_RST = 32'h0000_0000;
  localparam logic [7:0]  SYN_RST     = 8'h00;
  localparam logic [3:0]  TALLY_RST   = 4'h0;
  localparam logic [3:0]  TALLY_MAX   = 4'hf;
  localparam logic [1:0]  TYPE_RST    = 2'h0;
  localparam logic [1:0]  TYPE_MULTI  = 2'h3;
  localparam logic [1:0]  TYPE_SINGLE = 2'h2;
  localparam logic [1:0]  DIAG_RSVD   = 2'h0;
  localparam logic [7:0]  CB_USED_32  = 8'h7f;
  localparam logic [7:0]  CB_USED_64  = 8'hff;
  // code column weights: lower half and upper half
  localparam int COL_W_LO = 3;
  localparam int COL_W_HI = 5;

  // j-th 8-bit column of weight w, in ascending order
  function automatic logic [7:0] fedc_col(input int j, input int w);
    int n;
    logic [7:0] r;
    n = 0;
    r = 8'h00;
    for (int v = 0; v < 256; v++) begin
      if ($countones(8'(v)) == w) begin
        if (n == j) r = 8'(v);
        n++;
      end
    end
    return r;
  endfunction

  // check bits over one 32-bit half
  function automatic logic [7:0] fedc_gen(input logic [31:0] d, input int w);
    logic [7:0] c;
    c = 8'h00;
    for (int j = 0; j < 32; j++) begin
      if (d[j]) c = c ^ fedc_col(j, w);
    end
    return c;
  endfunction

  // data bit whose column equals the syndrome
  function automatic logic [31:0] fedc_flip(input logic [7:0] s, input int w);
    logic [31:0] f;
    f = 32'h0000_0000;
    for (int j = 0; j < 32; j++) begin
      f[j] = (s == fedc_col(j, w));
    end
    return f;
  endfunction
endpackage
`default_nettype wire

// ==== core/fedc_pair_buf.sv ====
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module fedc_pair_buf #(
  parameter int W = 40
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         resetn_i,
  // filling side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output var  logic         in_ready_o,
  // draining side
  output var  logic         out_valid_o,
  output var  logic [W-1:0] out_data_o,
  input  wire logic         out_ready_i
);
  logic [1:0]   count;
  logic [W-1:0] tail;
  wire          push = in_valid_i & in_ready_o;
  wire          pop  = out_valid_o & out_ready_i;
  wire [1:0]    next_count = count + {1'b0, push} - {1'b0, pop};
  wire          head_from_in = push & ((count == 2'd0) | ((count == 2'd1) & pop));
  wire          head_from_tail = pop & (count == 2'd2);
  wire          tail_load = push & (count == 2'd1) & ~pop;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count       <= 2'd0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
      tail        <= '0;
    end else begin
      count       <= next_count;
      in_ready_o  <= next_count != 2'd2;
      out_valid_o <= next_count != 2'd0;
      if (head_from_in) out_data_o <= in_data_i;
      else if (head_from_tail) out_data_o <= tail;
      if (tail_load) tail <= in_data_i;
    end
  end

  a_buf_no_overrun: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
    else $error("buffer head changed while stalled");
endmodule // fedc_pair_buf
`default_nettype wire

// ==== testbench/fedc_mem_model.sv ====
// memory side model: takes buffered writes, promptly or with stalls
`timescale 1ns/1ps
`default_nettype none
module fedc_mem_model (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  // write side
  input  wire logic wr_valid_i,
  input  wire logic stall_i,
  output var  logic accept_o
);
  // random readiness, held off while stalled
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      accept_o <= 1'b0;
    end else begin
      accept_o <= wr_valid_i && !stall_i && ($urandom_range(2, 0) != 0);
    end
  end
endmodule // fedc_mem_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the flow-through edc slice
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fedc_pkg::*;
  logic        clk, rst_n, podd, soe_n, pfail_n, sle, mle, ple, mwr, mwr_rdy, macc, md_oe, err_n;
  logic        dclk, dclk_en_n, dclr, stall, mk0;
  logic [1:0]  cfg, mk_d;
  logic [2:0]  mode;
  logic [3:0]  sd_oe, par_i, par_o, par_oe, be_n, pv;
  logic [7:0]  checkbit_in, partial_checkbit_in, checkbit_out, syndrome_out, c, cx, p;
  logic [31:0] sd_i, sd_o, md_i, md_o, d, f, x, s, m;
  logic [2:0]  mt[5] = '{3'h3, 3'h7, 3'h2, 3'h6, 3'h4};
  logic [32:0] rdq[$];
  logic [39:0] wrq[$];
  int          mismatches, num_checks, k, i;

  fedc_slice i_dut (.sys_clk_i(clk), .resetn_i(rst_n), .mode_select_i(mode), .slice_config_i(cfg),
    .parity_odd_i(podd), .system_bus_i(sd_i), .system_bus_o(sd_o), .system_bus_oe_o(sd_oe), .parity_i(par_i),
    .parity_o(par_o), .parity_oe_o(par_oe), .byte_enable_n_i(be_n), .system_output_enable_n_i(soe_n),
    .parity_fail_n_o(pfail_n), .sys_latch_en_i(sle), .mem_latch_en_i(mle), .pipe_latch_en_i(ple),
    .memory_bus_i(md_i), .memory_bus_o(md_o), .memory_bus_oe_o(md_oe), .mem_write_i(mwr),
    .mem_write_ready_o(mwr_rdy), .mem_accept_i(macc), .checkbit_in_i(checkbit_in), .partial_checkbit_in_i(partial_checkbit_in),
    .checkbit_out_o(checkbit_out), .syndrome_out_o(syndrome_out), .error_n_o(err_n), .diag_clock_i(dclk),
    .diag_clock_enable_n_i(dclk_en_n), .diag_clear_i(dclr));
  fedc_mem_model i_mem (.sys_clk_i(clk), .resetn_i(rst_n), .wr_valid_i(md_oe), .stall_i(stall), .accept_o(macc));

  function automatic logic [7:0] col(int j, int w);
    int n = 0;
    for (int v = 1; v < 256; v++) begin
      if ($countones(v[7:0]) == w) begin
        if (n == j) return v[7:0];
        n++;
      end
    end
    return 8'h00;
  endfunction

  function automatic logic [7:0] gen(logic [31:0] dd, int w);
    logic [7:0] r = 8'h00;
    for (int j = 0; j < 32; j++) if (dd[j]) r = r ^ col(j, w);
    return r;
  endfunction

  task automatic chk(logic a, logic e);
    num_checks++;
    if (a !== e) begin
      mismatches++;
      $display("unexpected t=%0t flag %b exp %b", $time, a, e);
    end
  endtask

  task automatic cmp_rd(logic [32:0] e);
    logic [3:0] ep, eo;
    eo = ~be_n & {4{~soe_n}};
    for (int b = 0; b < 4; b++) ep[b] = ^e[8*b +: 8] ^ podd;
    num_checks++;
    if ({err_n, sd_o} !== e || sd_oe !== eo || par_oe !== eo || par_o !== ep) begin
      mismatches++;
      $display("unexpected t=%0t read %b %h exp %h", $time, err_n, sd_o, e);
    end
  endtask

  task automatic cmp_wr(logic [39:0] e);
    num_checks++;
    if ({checkbit_out, md_o} !== e) begin
      mismatches++;
      $display("unexpected t=%0t write %h %h exp %h", $time, checkbit_out, md_o, e);
    end
  endtask

  task automatic rd(logic [31:0] dd, logic [7:0] cc, logic [32:0] e);
    md_i <= dd;
    checkbit_in <= cc;
    mle <= 1'b1;
    mk0 <= 1'b1;
    rdq.push_back(e);
    @(posedge clk);
    mle <= 1'b0;
    mk0 <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic pulse();
    dclk <= 1'b0;
    @(posedge clk);
    dclk <= 1'b1;
    @(posedge clk);
    dclk <= 1'b0;
    @(posedge clk);
  endtask

  task automatic push(logic [39:0] e);
    int n;
    wrq.push_back(e);
    mwr <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (mwr_rdy) break;
    end
    mwr <= 1'b0;
    if (n == 200) begin
      mismatches++;
      $display("unexpected t=%0t write not taken", $time);
    end
  endtask

  task automatic drain();
    for (int n = 0; n < 200 && wrq.size() > 0; n++) @(posedge clk);
    if (wrq.size() > 0) begin
      mismatches++;
      $display("unexpected t=%0t writes not drained", $time);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // result watcher: reads two edges after launch, writes when memory takes them
  always @(posedge clk) begin
    mk_d <= {mk_d[0], mk0};
    if (mk_d[1]) cmp_rd(rdq.pop_front());
    if (md_oe && macc) cmp_wr(wrq.pop_front());
  end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #100000;
    mismatches++;
    $display("unexpected t=%0t watchdog expired", $time);
    conclude();
  end

  initial begin
    void'($urandom(32'h6d2c));
    {rst_n, podd, soe_n, sle, mle, ple, mwr, dclk, dclr, stall, mk0} = '0;
    {cfg, be_n, par_i, sd_i, md_i, checkbit_in, partial_checkbit_in} = '0;
    mode = MODE_NORMAL;
    dclk_en_n = 1'b1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (mt[j]) for (int e = 0; e < 2; e++) begin
      d = $urandom;
      k = $urandom_range(31, 0);
      c = gen(d, 3);
      f = e ? 32'h1 << k : 32'h0;
      mode <= mt[j];
      podd <= $urandom_range(1, 0);
      sd_i <= {24'h5a5a5a, c};
      sle <= 1'b1;
      @(posedge clk);
      sle <= 1'b0;
      rd(d ^ f, mt[j] == MODE_INJECT ? ~c : c, {e == 0, mt[j][1:0] == MODE_GENDET ? d ^ f : d});
      chk(syndrome_out === (gen(d ^ f, 3) ^ c), 1'b1);
    end
    $display("test modes done");
    mode <= MODE_ERRDATA;
    dclr <= 1'b1;
    dclk_en_n <= 1'b0;
    @(posedge clk);
    dclr <= 1'b0;
    d = $urandom;
    rd(d, gen(d, 3), {1'b1, ERRDATA_RST});
    k = $urandom_range(31, 0);
    f = 32'h1 << k;
    rd(d ^ f, gen(d, 3), {1'b0, ERRDATA_RST});
    pulse();
    x = $urandom;
    cx = gen(x, 3);
    rd(x ^ 32'h1, cx, {1'b0, d ^ f});
    pulse();
    p = $urandom;
    mode <= 3'h1;
    partial_checkbit_in <= p;
    rd(x ^ 32'h1, cx, {1'b0, TYPE_SINGLE, DIAG_RSVD, 4'h2, col(k, 3), p, cx});
    dclr <= 1'b1;
    @(posedge clk);
    dclr <= 1'b0;
    i = k % 16;
    f = (32'h1 << i) | (32'h1 << (i + 16));
    rd(x ^ f, cx, {1'b0, TYPE_RST, DIAG_RSVD, TALLY_RST, SYN_RST, p, cx});
    repeat (17) pulse();
    rd(x ^ f, cx, {1'b0, TYPE_MULTI, DIAG_RSVD, TALLY_MAX, col(i, 3) ^ col(i + 16, 3), p, cx});
    $display("test diagnostics done");
    soe_n <= 1'b1;
    @(posedge clk);
    for (int o = 0; o < 2; o++) for (int b = 0; b < 5; b++) begin
      x = $urandom;
      podd <= o[0];
      for (int j = 0; j < 4; j++) pv[j] = ^x[8*j +: 8] ^ o[0] ^ (j == b);
      sd_i <= x;
      par_i <= pv;
      repeat (2) @(posedge clk);
      chk(pfail_n, b == 4);
    end
    soe_n <= 1'b0;
    $display("test parity done");
    mode <= MODE_NORMAL;
    stall <= 1'b1;
    for (int b = 0; b < 4; b++) begin
      d = $urandom;
      s = $urandom;
      be_n <= 4'h0;
      rd(d ^ (32'h1 << b * 7), gen(d, 3), {1'b0, d});
      ple <= 1'b1;
      @(posedge clk);
      ple <= 1'b0;
      sd_i <= s;
      sle <= 1'b1;
      @(posedge clk);
      sle <= 1'b0;
      m = d;
      m[8*b +: 8] = s[8*b +: 8];
      be_n <= ~(4'h1 << b);
      push({gen(m, 3), m});
      if (b == 1) begin
        @(posedge clk);
        chk(mwr_rdy, 1'b0);
        stall <= 1'b0;
      end
    end
    drain();
    $display("test partial write done");
    for (int h = 0; h < 2; h++) begin
      cfg <= h ? CFG_UPPER : CFG_LOWER;
      d = $urandom;
      s = $urandom;
      k = $urandom_range(31, 0);
      f = 32'h1 << k;
      c = gen(d, 3) ^ gen(s, 5);
      partial_checkbit_in <= h ? 8'h00 : gen(s, 5);
      rd(h ? s ^ f : d ^ f, h ? gen(s, 5) : c, {1'b0, h ? s : d});
    end
    $display("test cascade done");
    cfg <= CFG_GEN64;
    be_n <= 4'h0;
    repeat (2) begin
      d = $urandom;
      s = $urandom;
      md_i <= d;
      sd_i <= s;
      mle <= 1'b1;
      sle <= 1'b1;
      @(posedge clk);
      mle <= 1'b0;
      sle <= 1'b0;
      push({gen(d, 3) ^ gen(s, 5), d});
    end
    drain();
    chk(sd_oe === 4'h0, 1'b1);
    chk(err_n, 1'b1);
    $display("test wide generate done");
    conclude();
  end
endmodule // tb_top
`default_nettype wire
